// ---- cycle_timer.sv ----
// Purpose: loadable down counter for strobe timing
// Assumes: load value at least one
// Notes: done is high while the count is zero
`timescale 1ns/1ps
module cycle_timer
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] value_in,
   output logic                  done_out
);
   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;

   always_comb
   begin
      count_nxt = count_r;
      if (load_in)
      begin
         count_nxt = value_in;
      end
      else if (count_r != '0)
      begin
         count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         count_r <= '0;
      end
      else
      begin
         count_r <= count_nxt;
      end
   end

   assign done_out = (count_r == '0);
endmodule // cycle_timer

// ---- sram_device_model.sv ----
// Purpose: behavioural model of the static memory
// Assumes: 55 ns grade
// Notes: floating lines show the inverse of the last read byte
`timescale 1ns/1ps
module sram_device_model
(
   input  wire logic [16:0] address_lines_in,
   input  wire logic        chip_select_n_in,
   input  wire logic        chip_select_active_high_in,
   input  wire logic        write_strobe_n_in,
   input  wire logic        output_enable_n_in,
   input  wire logic [7:0]  host_data_in,
   input  wire logic        host_oe_in,
   output logic [7:0]       data_lines_out
);
   logic [7:0] mem [0:131071];
   logic [7:0] last_r = 8'h5a;
   logic       sel, rd_now;
   logic       rd_late = 1'b0;
   assign sel = !chip_select_n_in && chip_select_active_high_in;
   assign rd_now = sel && write_strobe_n_in
                   && !output_enable_n_in;
   // access time counts afresh from every start of a read
   always @(rd_now)
   begin
      if (rd_now)
         rd_late = 1'b0;
      rd_late <= #55 rd_now;
   end
   always @*
   begin
      if (sel && !write_strobe_n_in && host_oe_in)
         mem[address_lines_in] = host_data_in;
   end
   always @(negedge rd_now)
      last_r = ~mem[address_lines_in];
   assign data_lines_out = host_oe_in ? host_data_in :
      (rd_now && rd_late) ? mem[address_lines_in] : last_r;
endmodule // sram_device_model

// ---- sram_host.sv ----
// Purpose: host controller driving an asynchronous static memory
// Assumes: one request at a time, user holds request until ready
// Notes: strobes come from flip-flops; data lines split into in/out/oe
`timescale 1ns/1ps
module sram_host
#(
   parameter int ADDR_W     = sram_host_pkg::ADDR_W,
   parameter int DATA_W     = sram_host_pkg::DATA_W,
   parameter int ACCESS_CYC = sram_host_pkg::ACCESS_CYC,
   parameter int WP_CYC     = sram_host_pkg::WP_CYC,
   parameter int HZ_CYC     = sram_host_pkg::HZ_CYC
)
(
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   input  wire logic              req_valid_in,
   input  wire logic              req_write_in,
   input  wire logic [ADDR_W-1:0] req_addr_in,
   input  wire logic [DATA_W-1:0] req_wdata_in,
   output logic                   req_ready_out,
   output logic                   rd_valid_out,
   output logic [DATA_W-1:0]      rd_data_out,
   output logic [ADDR_W-1:0]      address_lines_out,
   output logic                   chip_select_n_out,
   output logic                   chip_select_active_high_out,
   output logic                   write_strobe_n_out,
   output logic                   output_enable_n_out,
   input  wire logic [DATA_W-1:0] data_lines_in,
   output logic [DATA_W-1:0]      data_lines_out,
   output logic                   data_lines_oe_out
);
   localparam int CW = sram_host_pkg::CNT_W;

   sram_host_pkg::host_state_t state_r;
   sram_host_pkg::host_state_t state_nxt;
   logic [ADDR_W-1:0] addr_r;
   logic [ADDR_W-1:0] addr_nxt;
   logic [DATA_W-1:0] wdata_r;
   logic [DATA_W-1:0] wdata_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic              rd_valid_r;
   logic              rd_valid_nxt;
   logic              cs_n_r;
   logic              cs_n_nxt;
   logic              we_n_r;
   logic              we_n_nxt;
   logic              oe_n_r;
   logic              oe_n_nxt;
   logic              drive_r;
   logic              drive_nxt;
   logic [DATA_W-1:0] dq_s1_r;
   logic [DATA_W-1:0] dq_s2_r;
   logic              tmr_load;
   logic [CW-1:0]     tmr_value;
   logic              tmr_done;

   cycle_timer #(.WIDTH(CW)) timer_u
   (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .load_in  (tmr_load),
      .value_in (tmr_value),
      .done_out (tmr_done)
   );

   // two-stage synchroniser on returning read data
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         dq_s1_r <= sram_host_pkg::DATA_RST;
         dq_s2_r <= sram_host_pkg::DATA_RST;
      end
      else
      begin
         dq_s1_r <= data_lines_in;
         dq_s2_r <= dq_s1_r;
      end
   end

   always_comb
   begin
      state_nxt    = state_r;
      addr_nxt     = addr_r;
      wdata_nxt    = wdata_r;
      rdata_nxt    = rdata_r;
      rd_valid_nxt = 1'b0;
      cs_n_nxt     = cs_n_r;
      we_n_nxt     = we_n_r;
      oe_n_nxt     = oe_n_r;
      drive_nxt    = drive_r;
      tmr_load     = 1'b0;
      tmr_value    = '0;
      unique case (state_r)
         sram_host_pkg::ST_IDLE:
         begin
            if (req_valid_in)
            begin
               // address registered on the same edge that select falls
               addr_nxt  = req_addr_in;
               wdata_nxt = req_wdata_in;
               if (req_write_in)
               begin
                  // select first, strobes high, lines still floating
                  cs_n_nxt  = 1'b0;
                  state_nxt = sram_host_pkg::ST_WR_SETUP;
               end
               else
               begin
                  cs_n_nxt  = 1'b0;
                  oe_n_nxt  = 1'b0;
                  tmr_load  = 1'b1;
                  // two extra cycles cover the input synchroniser
                  tmr_value = CW'(ACCESS_CYC + 2);
                  state_nxt = sram_host_pkg::ST_RD_ACCESS;
               end
            end
         end
         sram_host_pkg::ST_RD_ACCESS:
         begin
            if (tmr_done)
            begin
               rdata_nxt    = dq_s2_r;
               rd_valid_nxt = 1'b1;
               cs_n_nxt     = 1'b1;
               oe_n_nxt     = 1'b1;
               tmr_load     = 1'b1;
               // wait for device to release the lines
               tmr_value    = CW'(HZ_CYC);
               state_nxt    = sram_host_pkg::ST_RECOVER;
            end
         end
         sram_host_pkg::ST_WR_SETUP:
         begin
            // output enable stays high, so device never drives here
            drive_nxt = 1'b1;
            we_n_nxt  = 1'b0;
            tmr_load  = 1'b1;
            // pulse length also covers the data setup time
            tmr_value = CW'(WP_CYC);
            state_nxt = sram_host_pkg::ST_WR_PULSE;
         end
         sram_host_pkg::ST_WR_PULSE:
         begin
            if (tmr_done)
            begin
               // write ends on strobe rise; address and data still held
               we_n_nxt  = 1'b1;
               tmr_load  = 1'b1;
               tmr_value = CW'(1);
               state_nxt = sram_host_pkg::ST_RECOVER;
            end
         end
         sram_host_pkg::ST_RECOVER:
         begin
            cs_n_nxt = 1'b1;
            if (we_n_r && cs_n_r)
            begin
               drive_nxt = 1'b0;
            end
            if (tmr_done && cs_n_r)
            begin
               state_nxt = sram_host_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_r    <= sram_host_pkg::ST_IDLE;
         addr_r     <= sram_host_pkg::ADDR_RST;
         wdata_r    <= sram_host_pkg::DATA_RST;
         rdata_r    <= sram_host_pkg::DATA_RST;
         rd_valid_r <= 1'b0;
         cs_n_r     <= 1'b1;
         we_n_r     <= 1'b1;
         oe_n_r     <= 1'b1;
         drive_r    <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         addr_r     <= addr_nxt;
         wdata_r    <= wdata_nxt;
         rdata_r    <= rdata_nxt;
         rd_valid_r <= rd_valid_nxt;
         cs_n_r     <= cs_n_nxt;
         we_n_r     <= we_n_nxt;
         oe_n_r     <= oe_n_nxt;
         drive_r    <= drive_nxt;
      end
   end

   assign req_ready_out               = (state_r == sram_host_pkg::ST_IDLE);
   assign rd_valid_out                = rd_valid_r;
   assign rd_data_out                 = rdata_r;
   assign address_lines_out           = addr_r;
   assign chip_select_n_out           = cs_n_r;
   assign chip_select_active_high_out = 1'b1;
   assign write_strobe_n_out          = we_n_r;
   assign output_enable_n_out         = oe_n_r;
   assign data_lines_out              = wdata_r;
   assign data_lines_oe_out           = drive_r;
endmodule // sram_host

// ---- sram_host_assertions.sv ----
// Purpose: pin protocol checks on the memory host
// Assumes: 55 ns grade at 100 MHz
// Notes: bound into sram_host
`timescale 1ns/1ps
module sram_host_assertions
(
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic        rd_valid_out,
   input wire logic [16:0] address_lines_out,
   input wire logic        chip_select_n_out,
   input wire logic        chip_select_active_high_out,
   input wire logic        write_strobe_n_out,
   input wire logic        output_enable_n_out,
   input wire logic [7:0]  data_lines_out,
   input wire logic        data_lines_oe_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_wr_pulse;
      (!write_strobe_n_out && data_lines_oe_out
       && $stable(data_lines_out))[*7];
   endsequence
   sequence s_rd_wait;
      (!output_enable_n_out && !chip_select_n_out)[*8];
   endsequence
   sel_tied_high_a:
      assert property (chip_select_active_high_out
         && (output_enable_n_out || !chip_select_n_out))
      else $error("read enabled while deselected");
   no_contention_a:
      assert property (data_lines_oe_out |-> output_enable_n_out)
      else $error("host drives while reads enabled");
   wr_setup_a:
      assert property ($fell(write_strobe_n_out) |-> s_wr_pulse
         ##1 write_strobe_n_out) else $error("write pulse wrong");
   wr_addr_hold_a:
      assert property (!write_strobe_n_out |-> $stable(address_lines_out))
      else $error("address moved in write");
   sel_addr_hold_a:
      assert property (!chip_select_n_out && !$fell(chip_select_n_out)
         |-> $stable(address_lines_out)) else $error("address moved");
   rd_answer_a:
      assert property ($fell(output_enable_n_out) |-> s_rd_wait
         ##1 !output_enable_n_out ##1 rd_valid_out)
      else $error("read answer late");
   wr_selected_a:
      assert property (!write_strobe_n_out |-> !chip_select_n_out
         && output_enable_n_out) else $error("write unselected");
   wr_release_a:
      assert property ($rose(write_strobe_n_out) |-> data_lines_oe_out
         ##1 chip_select_n_out ##1 !data_lines_oe_out)
      else $error("write release order wrong");
endmodule // sram_host_assertions
bind sram_host sram_host_assertions i_sram_host_assertions
   (.clk_in, .reset_in, .rd_valid_out, .address_lines_out,
    .chip_select_n_out, .chip_select_active_high_out,
    .write_strobe_n_out, .output_enable_n_out, .data_lines_out,
    .data_lines_oe_out);

// ---- sram_host_pkg.sv ----
// Purpose: constants for the static memory host controller
// Assumes: 100 MHz clock, 55 ns speed grade by default
// Notes: times in ns, cycle counts derived from the clock period
//
// Notes on behaviour
// - data lines shared; device drives on reads, host drives on writes.
// - host holds write data valid 25 ns before the ending edge.
// - host never drives data lines while the device may drive them.
// - host holds address stable until write ends; recovery is zero.
// - host presents valid address no later than select falling edge.
package sram_host_pkg;
   localparam int ADDR_W       = 17;
   localparam int DATA_W       = 8;
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_ACCESS_NS  = 55;
   localparam int T_WP_NS      = 55;
   localparam int T_DW_NS      = 25;
   localparam int T_HZ_NS      = 25;
   localparam int ACCESS_CYC   = (T_ACCESS_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int WP_CYC       = (T_WP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int DW_CYC       = (T_DW_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int HZ_CYC       = (T_HZ_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
   localparam int CNT_W        = 8;
   localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   typedef enum {
      ST_IDLE,
      ST_RD_ACCESS,
      ST_WR_SETUP,
      ST_WR_PULSE,
      ST_RECOVER
   } host_state_t;
endpackage

// ---- sram_host_tb.sv ----
// Purpose: self-checking bench for the memory host
// Assumes: device model on the far side
// Notes: read results checked in issue order
`timescale 1ns/1ps
module sram_host_tb;
   logic        clk_in, reset_in, req_valid_in, req_write_in;
   logic [16:0] req_addr_in, addr;
   logic [7:0]  req_wdata_in, rd_data_out, hdata, dq;
   logic        req_ready_out, rd_valid_out, cs_n, cs_hi, we_n, oe_n, oe;
   logic [7:0]  exp_q [$];
   logic [7:0]  ref_m [int];
   logic [16:0] aq [12];
   int          errors, checks, cyc;
   sram_host i_sram_host (.clk_in, .reset_in, .req_valid_in,
      .req_write_in, .req_addr_in, .req_wdata_in, .req_ready_out,
      .rd_valid_out, .rd_data_out, .address_lines_out(addr),
      .chip_select_n_out(cs_n), .chip_select_active_high_out(cs_hi),
      .write_strobe_n_out(we_n), .output_enable_n_out(oe_n),
      .data_lines_in(dq), .data_lines_out(hdata),
      .data_lines_oe_out(oe));
   sram_device_model i_sram_device_model (.address_lines_in(addr),
      .chip_select_n_in(cs_n), .chip_select_active_high_in(cs_hi),
      .write_strobe_n_in(we_n), .output_enable_n_in(oe_n),
      .host_data_in(hdata), .host_oe_in(oe), .data_lines_out(dq));
   task automatic chk(input string n, input logic [7:0] e, g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic req(input logic w, input logic [16:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk_in);
      while (req_ready_out !== 1'b1 && n < 100)
      begin
         n++;
         @(negedge clk_in);
      end
      if (n >= 100)
         errors++;
      req_valid_in = 1'b1;
      req_write_in = w;
      req_addr_in = a;
      req_wdata_in = d;
      if (w)
         ref_m[a] = d;
      else
         exp_q.push_back(ref_m[a]);
      @(negedge clk_in);
      req_valid_in = 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(negedge clk_in)
   begin
      if (rd_valid_out === 1'b1)
         chk("read data", exp_q.pop_front(), rd_data_out);
   end
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial
   begin
      reset_in = 1'b1;
      req_valid_in = 1'b0;
      req_write_in = 1'b0;
      req_addr_in = 17'h00000;
      req_wdata_in = 8'h00;
      void'($urandom(42718));
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("idle pins", 8'h17,
          {3'h0, req_ready_out, oe, cs_n, we_n, oe_n});
      reset_in = 1'b0;
      req(1, 17'h00000, 8'h3c);
      req(1, 17'h1ffff, 8'hc3);
      req(0, 17'h00000, 8'h00);
      req(0, 17'h1ffff, 8'h00);
      $display("test boundary done");
      for (int i = 0; i < 12; i++)
      begin
         aq[i] = 17'($urandom_range(0, 131071));
         req(1, aq[i], 8'($urandom));
      end
      repeat (2)
         for (int i = 0; i < 12; i++)
            req(0, aq[i], 8'h00);
      req(1, aq[0], ~ref_m[aq[0]]);
      req(0, aq[0], 8'h00);
      $display("test random done");
      repeat (30) @(negedge clk_in);
      chk("queue left", 8'h00, 8'(exp_q.size()));
      tally_and_finish();
   end
endmodule // sram_host_tb
